/* File: shared/sleep_ctl_pkg.sv */
// Package with constants, register map and state types of the cyclic sleep controller.
package sleep_ctl_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS   = 4;
	localparam int unsigned TICK_PERIOD_NS  = 10_000_000;
	localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam int unsigned TICK_MS         = 10;
	localparam int unsigned POLL_PERIOD_MS  = 100;
	localparam int unsigned POLL_TICKS      = POLL_PERIOD_MS / TICK_MS;
	localparam int unsigned FAST_POLL_TICKS = 1;
	localparam int unsigned PB_WAKE_S       = 30;
	localparam int unsigned PB_TICKS        = PB_WAKE_S * 1000 / TICK_MS;
	localparam int unsigned LOST_POLLS      = 3;
	localparam int unsigned REJOIN_TRIES    = 3;
	localparam int unsigned TICK_W          = 22;

	// ----------------------------------------------------------------
	// Register map (byte addresses) and field values
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL_OFS   = 8'h00;
	localparam logic [7:0]  SP_OFS     = 8'h04;
	localparam logic [7:0]  SN_OFS     = 8'h08;
	localparam logic [7:0]  HOLD_OFS   = 8'h0c;
	localparam logic [7:0]  IR_OFS     = 8'h10;
	localparam logic [7:0]  IOEN_OFS   = 8'h14;
	localparam logic [7:0]  CMD_OFS    = 8'h18;
	localparam logic [7:0]  STAT_OFS   = 8'h1c;
	localparam logic [2:0]  STYLE_PIN  = 3'h1;
	localparam logic [2:0]  STYLE_CYC  = 3'h4;
	localparam logic [2:0]  STYLE_CYCP = 3'h5;
	localparam int unsigned OPT_FULL_B = 1;
	localparam int unsigned OPT_EXT_B  = 2;
	localparam logic [11:0] SP_MIN     = 12'h020;
	localparam logic [11:0] SP_MAX     = 12'haf0;
	localparam logic [11:0] SP_RST     = 12'h020;
	localparam logic [15:0] SN_RST     = 16'h0001;
	localparam logic [15:0] HOLD_RST   = 16'h0064;
	localparam logic [7:0]  NJ_RST     = 8'hff;
	localparam logic [7:0]  NJ_ASSOC   = 8'hff;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {S_JOIN, S_SLEEP, S_AWAKE} mode_t;
	typedef enum logic [1:0] {J_ORPHAN, J_REJOIN, J_ASSOC} join_t;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [7:0]  paddr;
		logic [31:0] pwdata;
	} apb_req_t;

	typedef struct packed {
		logic rf_rx;
		logic serial_rx;
		logic poll_ack;
		logic ack_pending;
		logic poll_noack;
		logic join_ok;
		logic join_fail;
		logic tx_start;
		logic tx_ack;
	} radio_in_t;

	typedef struct packed {
		logic  poll_req;
		logic  io_sample_req;
		logic  join_req;
		join_t join_kind;
	} radio_out_t;

	typedef struct packed {
		mode_t              st;
		join_t              jph;
		logic               jstart;
		logic [1:0]         rejoin_cnt;
		logic [TICK_W-1:0]  tick_cnt;
		logic [27:0]        sleep_cnt;
		logic [15:0]        wake_cnt;
		logic [15:0]        hold_cnt;
		logic               hold_run;
		logic [3:0]         poll_cnt;
		logic               fast;
		logic               poll_wait;
		logic [1:0]         miss;
		logic [15:0]        samp_cnt;
		logic [11:0]        pb_cnt;
		logic               tx_wait;
		logic               show;
		logic               ind;
		logic               cts_n;
		logic               pin_s1;
		logic               pin_s2;
		logic               pin_s3;
		logic               pb_s1;
		logic               pb_s2;
		logic               pb_s3;
		logic [2:0]         style;
		logic               flow_en;
		logic               pb_en;
		logic [7:0]         opt;
		logic [7:0]         nj;
		logic [11:0]        sp;
		logic [15:0]        sn;
		logic [15:0]        hold_val;
		logic [15:0]        ir;
		logic [15:0]        io_en;
		logic [31:0]        prdata;
		radio_out_t         ro;
	} state_t;

endpackage

/* File: design/cyclic_sleep_controller.sv */
// Sleep and wake sequencer for a battery-powered end device, with APB configuration.
//
// Behaviour
// RQ1: Sleep style 4 or 5 selects cyclic sleep: timed sleep, short wake.
// RQ2: Style 5 also wakes on a falling sleep request pin; style 4 does not.
// RQ3: Each cyclic wake polls; pending data or serial input keeps it awake.
// RQ4: Awake indicator high while awake, low while sleeping.
// RQ5: With flow control enabled, cts_n low when awake, high when asleep.
// RQ6: Serial or RF data starts, and restarts, the wake-hold timer.
// RQ7: While the wake-hold timer runs, a poll goes out every 100 ms.
// RQ8: Sleep when the wake-hold timer expires or on the sleep-now command.
// RQ9: Sleep period accepts 0x20 to 0xaf0 in 10 ms units.
// RQ10: Sleep period multiplier accepts 1 to 0xffff.
// RQ11: Option 0x02 holds awake for full hold time; 0x04 enables extended sleep.
// RQ12: Options 0x00 or 0x02 give short sleep: one period, then poll.
// RQ13: Short sleep: multiplier 1 shows every wake, else RF data or N wakes.
// RQ14: Extended sleep lasts period times multiplier, in 10 ms units.
// RQ15: Cyclic sleep polls once per wake unless the hold timer was started.
// RQ16: Pin sleep polls every 100 ms while the sleep request pin is low.
// RQ17: RF data from parent gives a fast poll; back to 100 ms afterwards.
// RQ18: With sampling enabled, sample on wake, start hold, sample each interval.
// RQ19: Enabled pushbutton falling edge wakes the device for 30 seconds; while asleep in pin sleep (style 1) the code ignores it.
// RQ20: Three unacknowledged polls in a row mean the parent is lost.
// RQ21: After reset do an orphan scan; on no response search a new parent.
// RQ22: Join permit below 0xff tries rejoin first, then association.
// RQ23: Transmit only to the parent and wait for its acknowledgment.
// RQ24: 10 ms and 100 ms ticks come from prescalers cleared by reset.
`timescale 1ns/1ps
`default_nettype none

module cyclic_sleep_controller #(
	parameter int unsigned TICK_CYCLES = sleep_ctl_pkg::TICK_CYCLES_DEF
) (
	// Clock and reset.
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// APB slave.
	input  wire sleep_ctl_pkg::apb_req_t  apb_req,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// Module pins.
	input  wire logic                     sleep_request_pin,
	input  wire logic                     pushbutton_input,
	output logic                          awake_indicator,
	output logic                          cts_n,
	// Radio stack and host events.
	input  wire sleep_ctl_pkg::radio_in_t ri,
	output sleep_ctl_pkg::radio_out_t     ro
);
	import sleep_ctl_pkg::*;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------

	// Register decode, used only by the error answer; read and write decode the address themselves.
	function automatic logic mapped(input logic [7:0] a);
		return a[1:0] == 2'h0 && a <= STAT_OFS;
	endfunction

	// Sampling on wake needs a non-zero interval and an enabled line.
	function automatic logic samp_on(input state_t s);
		return s.ir != 16'h0000 && s.io_en != 16'h0000;
	endfunction

	function automatic logic cyclic(input state_t s);
		return s.style == STYLE_CYC || s.style == STYLE_CYCP;
	endfunction

	// Common entry into the awake state: first poll goes out at once.
	function automatic state_t enter_wake(input state_t s, input logic show);
		state_t r;
		r = s;
		r.st          = S_AWAKE;
		r.show        = show;
		r.ro.poll_req = 1'b1; // [RQ3]
		r.poll_wait   = 1'b1;
		r.poll_cnt    = '0;
		r.fast        = 1'b0;
		r.samp_cnt    = '0;
		r.ro.io_sample_req = samp_on(s); // [RQ18]
		if (s.opt[OPT_FULL_B] || samp_on(s)) begin
			r.hold_run = 1'b1; // [RQ11] [RQ18]
			r.hold_cnt = s.hold_val;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	localparam state_t STATE_RST = '{st: S_JOIN, jph: J_ORPHAN, jstart: 1'b1,
		sp: SP_RST, sn: SN_RST, hold_val: HOLD_RST, nj: NJ_RST,
		ro: '{poll_req: 1'b0, io_sample_req: 1'b0, join_req: 1'b0, join_kind: J_ORPHAN},
		default: '0};

	state_t            q;
	state_t            d;
	logic              tick;
	logic              pin_fall;
	logic              pb_fall;
	logic              wr;
	logic [27:0]       target;
	logic [3:0]        gap;

	// Outputs straight from the state register, pslverr straight from the bus; pready never stalls.
	assign prdata          = q.prdata;
	assign awake_indicator = q.ind;
	assign cts_n           = q.cts_n;
	assign ro              = q.ro;
	assign pready          = 1'b1;
	assign pslverr         = apb_req.psel && apb_req.penable && !mapped(apb_req.paddr);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	// All behaviour lives here; pulses default low each cycle.
	always_comb begin
		d = q;
		d.ro.poll_req      = 1'b0;
		d.ro.io_sample_req = 1'b0;
		d.ro.join_req      = 1'b0;
		d.ro.join_kind     = q.jph;

		// Pins pass three flops; only the second and third feed edge logic.
		d.pin_s1 = sleep_request_pin;
		d.pin_s2 = q.pin_s1;
		d.pin_s3 = q.pin_s2;
		d.pb_s1  = pushbutton_input;
		d.pb_s2  = q.pb_s1;
		d.pb_s3  = q.pb_s2;
		pin_fall = q.pin_s3 && !q.pin_s2;
		pb_fall  = q.pb_en && q.pb_s3 && !q.pb_s2;

		// The 10 ms prescaler; polls count ten of its ticks, fast polls one.
		tick       = q.tick_cnt == TICK_W'(TICK_CYCLES - 1);
		d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1; // [RQ24]

		// Extended sleep spans period times multiplier, else one period.
		target = q.opt[OPT_EXT_B] ? 28'(q.sp) * 28'(q.sn) : 28'(q.sp); // [RQ12] [RQ14]
		gap    = q.fast ? 4'(FAST_POLL_TICKS) : 4'(POLL_TICKS); // [RQ17]

		// APB: read data captured in setup, writes take effect in access.
		wr = apb_req.psel && apb_req.penable && apb_req.pwrite;
		if (apb_req.psel && !apb_req.penable) begin
			unique case (apb_req.paddr)
				CTRL_OFS: d.prdata = {8'h00, q.nj, q.opt, 3'h0, q.pb_en, q.flow_en, q.style};
				SP_OFS:   d.prdata = {20'h00000, q.sp};
				SN_OFS:   d.prdata = {16'h0000, q.sn};
				HOLD_OFS: d.prdata = {16'h0000, q.hold_val};
				IR_OFS:   d.prdata = {16'h0000, q.ir};
				IOEN_OFS: d.prdata = {16'h0000, q.io_en};
				STAT_OFS: d.prdata = {20'h00000, q.tx_wait, q.hold_run, q.miss,
					q.jph, q.st, q.show, q.ind, q.poll_wait, q.fast};
				default:  d.prdata = 32'h00000000;
			endcase
		end
		if (wr && apb_req.paddr == CTRL_OFS) begin
			d.style   = apb_req.pwdata[2:0];
			d.flow_en = apb_req.pwdata[3];
			d.pb_en   = apb_req.pwdata[4];
			d.opt     = apb_req.pwdata[15:8];
			d.nj      = apb_req.pwdata[23:16];
		end
		// Out of range period or zero multiplier writes are dropped.
		if (wr && apb_req.paddr == SP_OFS && apb_req.pwdata[31:12] == 20'h00000
				&& apb_req.pwdata[11:0] >= SP_MIN && apb_req.pwdata[11:0] <= SP_MAX) begin
			d.sp = apb_req.pwdata[11:0]; // [RQ9]
		end
		if (wr && apb_req.paddr == SN_OFS && apb_req.pwdata[15:0] != 16'h0000) begin
			d.sn = apb_req.pwdata[15:0]; // [RQ10]
		end
		if (wr && apb_req.paddr == HOLD_OFS) begin
			d.hold_val = apb_req.pwdata[15:0];
		end
		if (wr && apb_req.paddr == IR_OFS) begin
			d.ir = apb_req.pwdata[15:0];
		end
		if (wr && apb_req.paddr == IOEN_OFS) begin
			d.io_en = apb_req.pwdata[15:0];
		end

		unique case (q.st)
			// Orphan scan after reset, then rejoin or association.
			S_JOIN: begin
				d.show = 1'b1;
				if (q.jstart) begin
					d.jstart      = 1'b0;
					d.ro.join_req = 1'b1; // [RQ21]
				end else if (ri.join_ok) begin
					d            = enter_wake(d, 1'b1);
					d.rejoin_cnt = '0;
					d.miss       = '0;
				end else if (ri.join_fail) begin
					d.jstart = 1'b1;
					unique case (q.jph)
						J_ORPHAN: d.jph = (q.nj == NJ_ASSOC) ? J_ASSOC : J_REJOIN; // [RQ21] [RQ22]
						J_REJOIN: begin
							if (q.rejoin_cnt == 2'(REJOIN_TRIES - 1)) begin
								d.jph = J_ASSOC; // [RQ22]
							end else begin
								d.rejoin_cnt = q.rejoin_cnt + 1'b1;
							end
						end
						J_ASSOC:  d.jph = J_ASSOC;
					endcase
				end
			end

			// Low power: count the period, watch pin and pushbutton.
			S_SLEEP: begin
				if (tick) begin
					d.sleep_cnt = q.sleep_cnt + 1'b1;
				end
				if (q.style == STYLE_PIN) begin
					if (!q.pin_s2) begin
						d = enter_wake(d, 1'b1);
					end
				end else if (!cyclic(q)) begin
					d = enter_wake(d, 1'b1);
				end else if (pb_fall) begin
					d        = enter_wake(d, 1'b1);
					d.pb_cnt = 12'(PB_TICKS); // [RQ19]
				end else if (q.style == STYLE_CYCP && pin_fall) begin
					d = enter_wake(d, 1'b1); // [RQ2]
				end else if (tick && q.sleep_cnt + 1'b1 >= target) begin // [RQ1] [RQ14]
					if (q.opt[OPT_EXT_B] || q.sn == 16'h0001) begin
						d = enter_wake(d, 1'b1); // [RQ13]
					end else if (q.wake_cnt + 1'b1 >= q.sn) begin
						d          = enter_wake(d, 1'b1); // [RQ13]
						d.wake_cnt = '0;
					end else begin
						d          = enter_wake(d, 1'b0); // [RQ12]
						d.wake_cnt = q.wake_cnt + 1'b1;
					end
				end
			end

			// Awake: polling, hold timer, sampling, parent supervision.
			S_AWAKE: begin
				if (ri.serial_rx || ri.rf_rx) begin
					d.hold_run = 1'b1; // [RQ6]
					d.hold_cnt = q.hold_val;
				end
				if (ri.rf_rx) begin
					d.show = 1'b1; // [RQ13]
					d.fast = 1'b1; // [RQ17]
				end
				if (pb_fall) begin
					d.pb_cnt = 12'(PB_TICKS); // [RQ19]
					d.show   = 1'b1;
				end
				// Host frames go to the parent only; hold awake for its ack.
				if (ri.tx_start) begin
					d.tx_wait = 1'b1; // [RQ23]
				end else if (ri.tx_ack) begin
					d.tx_wait = 1'b0;
				end
				if (tick && q.pb_cnt != 12'h000) begin
					d.pb_cnt = q.pb_cnt - 1'b1;
				end
				if (tick && q.hold_run && !(ri.serial_rx || ri.rf_rx)) begin
					if (q.hold_cnt == 16'h0000) begin
						d.hold_run = 1'b0; // [RQ8]
					end else begin
						d.hold_cnt = q.hold_cnt - 1'b1;
					end
				end
				// Repeat samples at the interval while the hold timer runs.
				if (tick && q.hold_run && samp_on(q)) begin
					if (q.samp_cnt + 1'b1 >= q.ir) begin
						d.ro.io_sample_req = 1'b1; // [RQ18]
						d.samp_cnt         = '0;
					end else begin
						d.samp_cnt = q.samp_cnt + 1'b1;
					end
				end
				// Periodic polls; the count runs during an outstanding poll so the spacing stays fixed.
				if (tick && (q.hold_run || q.fast || !cyclic(q))) begin
					if (q.poll_cnt + 1'b1 < gap) begin
						d.poll_cnt = q.poll_cnt + 1'b1;
					end else begin
						d.poll_cnt    = '0;
						d.ro.poll_req = !q.poll_wait; // [RQ7] [RQ16] [RQ17]
						d.poll_wait   = 1'b1;
						d.fast        = ri.rf_rx || (q.poll_wait && q.fast);
					end
				end
				if (ri.poll_ack && q.poll_wait) begin
					d.poll_wait = 1'b0;
					d.miss      = '0;
					if (ri.ack_pending) begin
						d.hold_run = 1'b1; // [RQ3]
						d.hold_cnt = q.hold_val;
					end
				end else if (ri.poll_noack && q.poll_wait) begin
					d.poll_wait = 1'b0;
					d.miss      = q.miss + 1'b1;
				end
				// Third missed poll rejoins; else sleep when idle, on pin high in pin sleep, or on the sleep-now command (bit 0 of the command word).
				if (ri.poll_noack && q.poll_wait && q.miss == 2'(LOST_POLLS - 1)) begin
					d.st     = S_JOIN; // [RQ20]
					d.jstart = 1'b1;
					d.jph    = (q.nj == NJ_ASSOC) ? J_ASSOC : J_REJOIN; // [RQ22]
					d.rejoin_cnt = '0;
					d.miss   = '0;
				end else if ((cyclic(q) && ((wr && apb_req.paddr == CMD_OFS && apb_req.pwdata[0])
						|| (!q.hold_run && !q.poll_wait && !q.tx_wait
						&& q.pb_cnt == 12'h000 && !ri.serial_rx && !ri.rf_rx)))
						|| (q.style == STYLE_PIN && q.pin_s2 && !q.poll_wait
						&& !q.tx_wait && q.pb_cnt == 12'h000)) begin
					d.st        = S_SLEEP; // [RQ3] [RQ8] [RQ15]
					d.sleep_cnt = '0;
					d.show      = 1'b0;
					d.hold_run  = 1'b0;
					d.fast      = 1'b0;
					d.poll_wait = 1'b0;
					d.pb_cnt    = '0;
				end
			end
			default: d.st = S_JOIN;
		endcase

		// Indicator and flow control follow the next state directly.
		d.ind   = d.st != S_SLEEP && d.show; // [RQ4]
		d.cts_n = q.flow_en ? !d.ind : 1'b0; // [RQ5]
	end

	// The single state register.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= STATE_RST;
		end else begin
			q <= d;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	ind_in_sleep_a: assert property (q.st == S_SLEEP |-> !awake_indicator) // [RQ4]
		else $error("awake indicator high while asleep");
	cts_follow_a: assert property (q.flow_en && $past(q.flow_en) |-> cts_n == !awake_indicator) // [RQ5]
		else $error("cts_n does not mirror awake state");
	wake_poll_a: assert property ($rose(q.st == S_AWAKE) |-> ro.poll_req && q.poll_wait) // [RQ3]
		else $error("no poll on wake");
	no_pin_wake_a: assert property (q.st == S_SLEEP && q.style == STYLE_CYC && !tick
			&& !(q.pb_en && q.pb_s3 && !q.pb_s2) |=> q.st == S_SLEEP) // [RQ2]
		else $error("style 4 left sleep without timer");
	lost_parent_a: assert property (q.st == S_AWAKE && q.poll_wait && ri.poll_noack
			&& q.miss == 2'h2 |=> q.st == S_JOIN ##1 ro.join_req) // [RQ20]
		else $error("third missed poll not handled");
	sp_range_a: assert property (q.sp >= SP_MIN && q.sp <= SP_MAX && q.sn != 16'h0000) // [RQ9]
		else $error("sleep period setting out of range");
	orphan_assoc_a: assert property (q.st == S_JOIN && !q.jstart && q.jph == J_ORPHAN
			&& ri.join_fail && !ri.join_ok && q.nj == NJ_ASSOC |=> q.jph == J_ASSOC) // [RQ22]
		else $error("join permit 0xff did not go to association");
	tick_bound_a: assert property (tick |=> q.tick_cnt == '0 ##1 q.tick_cnt == TICK_W'(1)) // [RQ24]
		else $error("prescaler not restarting");
	hold_sleep_a: assert property (q.st == S_AWAKE && cyclic(q) && q.hold_run
			&& !apb_req.psel |=> q.st != S_SLEEP) // [RQ8]
		else $error("slept with hold timer running");

	wake_cov_c:  cover property (q.st == S_SLEEP ##1 q.st == S_AWAKE);
	hold_cov_c:  cover property (q.hold_run ##1 !q.hold_run ##1 q.st == S_SLEEP);
	join_cov_c:  cover property (q.st == S_JOIN && ri.join_ok);
	quiet_cov_c: cover property (q.st == S_AWAKE && !q.show);

endmodule

`default_nettype wire

/* File: bench/parent_node_model.sv */
// Behavioural parent node that answers polls, joins and host frames of the end device.
`timescale 1ns/1ps
`default_nettype none

module parent_node_model (
	// Clock and reset.
	input  wire logic                      pclk,
	input  wire logic                      presetn,
	// Requests from the device and scenario knobs.
	input  wire sleep_ctl_pkg::radio_out_t ro,
	input  wire logic                      tx_start,
	input  wire logic [1:0]                mode,
	input  wire logic                      join_good,
	// Answers back to the device.
	output var  sleep_ctl_pkg::radio_in_t  pi
);
	import sleep_ctl_pkg::*;

	logic [3:0] poll_w;
	logic [3:0] tx_w;
	logic [1:0] join_w;

	// Each answer comes a fixed few cycles after its request, so the device
	// really has to wait for it; mode 2 keeps silent and reports a missed ack.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pi <= '0;
			poll_w <= 4'h0;
			tx_w <= 4'h0;
			join_w <= 2'h0;
		end else begin
			pi.poll_ack <= 1'b0;
			pi.poll_noack <= 1'b0;
			pi.join_ok <= 1'b0;
			pi.join_fail <= 1'b0;
			pi.tx_ack <= 1'b0;
			pi.ack_pending <= ~pi.ack_pending;  // Carries no meaning outside an ack.
			poll_w <= ro.poll_req ? 4'ha : ((poll_w != 4'h0) ? poll_w - 4'h1 : 4'h0);
			tx_w <= tx_start ? 4'hc : ((tx_w != 4'h0) ? tx_w - 4'h1 : 4'h0);
			join_w <= ro.join_req ? 2'h3 : ((join_w != 2'h0) ? join_w - 2'h1 : 2'h0);
			if (poll_w == 4'h1) begin
				pi.poll_ack <= (mode != 2'h2);
				pi.poll_noack <= (mode == 2'h2);
				pi.ack_pending <= mode[0];
			end
			if (tx_w == 4'h1) begin
				pi.tx_ack <= 1'b1;
			end
			if (join_w == 2'h1) begin
				pi.join_ok <= join_good;
				pi.join_fail <= !join_good;
			end
		end
	end
endmodule

`default_nettype wire

/* File: bench/cyclic_sleep_controller_tb_top.sv */
// Self-checking testbench of the cyclic sleep controller.
`timescale 1ns/1ps
`default_nettype none

module cyclic_sleep_controller_tb_top;
	import sleep_ctl_pkg::*;

	// ----------------------------------------------------------------
	// Signals
	// ----------------------------------------------------------------
	localparam int unsigned TC = 8;  // Short tick keeps the run brief.
	logic        pclk;
	logic        presetn;
	apb_req_t    apb_req;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        sleep_request_pin;
	logic        pushbutton_input;
	logic        awake_indicator;
	logic        cts_n;
	logic [2:0]  ev;
	logic [1:0]  mode;
	logic        join_good;
	radio_in_t   ri;
	radio_in_t   pi;
	radio_out_t  ro;
	int          fails;
	int          checked;
	int          n;
	logic [31:0] rd;
	logic        err;

	cyclic_sleep_controller #(.TICK_CYCLES(TC)) DUT (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sleep_request_pin(sleep_request_pin), .pushbutton_input(pushbutton_input),
		.awake_indicator(awake_indicator), .cts_n(cts_n), .ri(ri), .ro(ro));

	parent_node_model parent (.pclk(pclk), .presetn(presetn), .ro(ro), .tx_start(ev[2]),
		.mode(mode), .join_good(join_good), .pi(pi));

	// Host events merge into the partner's answers.
	always_comb begin
		ri = pi;
		ri.rf_rx = ev[0];
		ri.serial_rx = ev[1];
		ri.tx_start = ev[2];
	end

	// Free running clock at 250 MHz.
	initial pclk = 1'b0;
	always #2 pclk = ~pclk;

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
		end
	endtask

	// One APB transfer; the request holds until pready is seen at an edge.
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge pclk);
		apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		rd = prdata;
		err = pslverr;
		apb_req.psel <= 1'b0;
		apb_req.penable <= 1'b0;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check(rd, e);
	endtask

	function automatic logic watched(input int w);
		return (w == 0) ? awake_indicator : ((w == 1) ? ro.poll_req : ro.join_req);
	endfunction

	// Counts settled cycles until the watched output shows the level, up to a limit.
	task automatic wait_for(input int w, input logic v, input int lim);
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (watched(w) !== v && n < lim);
	endtask

	task automatic pulse(input logic [2:0] e);
		@(posedge pclk);
		ev <= e;
		@(posedge pclk);
		ev <= 3'h0;
	endtask

	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_join();
		wait_for(2, 1'b1, 20);
		check(32'(ro.join_kind), 32'(J_ORPHAN));
		check(32'(awake_indicator), 32'h1);
		wait_for(1, 1'b1, 200);
		wait_for(1, 1'b1, 200);
		wait_for(1, 1'b1, 200);
		check(32'(n), 32'(10 * TC));
	endtask

	task automatic t_regs();
		rdchk(SP_OFS, 32'h20);
		rdchk(SN_OFS, 32'h1);
		rdchk(HOLD_OFS, 32'h64);
		rdchk(CTRL_OFS, 32'h00ff_0000);
		apb(1'b0, 8'h20, 32'h0);
		check(32'(err), 32'h1);
		apb(1'b1, SP_OFS, 32'h1f);
		apb(1'b1, SP_OFS, 32'haf1);
		apb(1'b1, SN_OFS, 32'h0);
		rdchk(SP_OFS, 32'h20);
		rdchk(SN_OFS, 32'h1);
		apb(1'b1, SP_OFS, 32'haf0);
		apb(1'b1, SN_OFS, 32'hffff);
		rdchk(SP_OFS, 32'haf0);
		rdchk(SN_OFS, 32'hffff);
		apb(1'b1, SP_OFS, 32'h20);
		apb(1'b1, SN_OFS, 32'h1);
	endtask

	task automatic t_short();
		apb(1'b1, CTRL_OFS, 32'h0010_000c);
		apb(1'b1, CMD_OFS, 32'h1);
		wait_for(0, 1'b0, 20);
		check(32'({awake_indicator, cts_n}), 32'h1);
		wait_for(1, 1'b1, 300);
		check(32'(n >= 31 * TC && n <= 33 * TC), 32'h1);
		check(32'({awake_indicator, cts_n}), 32'h2);
		wait_for(0, 1'b0, 20);
		check(32'(n < 20), 32'h1);
	endtask

	task automatic t_pin();
		apb(1'b1, CTRL_OFS, 32'h0010_000d);
		repeat (40) @(posedge pclk);
		sleep_request_pin <= 1'b0;
		wait_for(1, 1'b1, 30);
		check(32'(n < 30), 32'h1);
		wait_for(0, 1'b0, 30);
		@(posedge pclk);
		sleep_request_pin <= 1'b1;
		apb(1'b1, CTRL_OFS, 32'h0010_000c);
		sleep_request_pin <= 1'b0;
		wait_for(1, 1'b1, 60);
		check(32'(n), 32'd60);
		@(posedge pclk);
		sleep_request_pin <= 1'b1;
	endtask

	task automatic t_hold();
		apb(1'b1, HOLD_OFS, 32'd20);
		wait_for(1, 1'b1, 300);
		pulse(3'h2);
		pulse(3'h4);
		apb(1'b0, STAT_OFS, 32'h0);
		check(32'(rd[11:10]), 32'h3);
		repeat (90) @(posedge pclk);
		apb(1'b0, STAT_OFS, 32'h0);
		check(32'(rd[11]), 32'h0);
		pulse(3'h2);
		pulse(3'h1);
		wait_for(1, 1'b1, 20);
		check(32'(n <= 2 * TC), 32'h1);
		repeat (80) @(posedge pclk);
		check(32'(awake_indicator), 32'h1);
		wait_for(0, 1'b0, 120);
		check(32'(n < 120), 32'h1);
	endtask

	task automatic t_lost();
		@(posedge pclk);
		mode <= 2'h2;
		join_good <= 1'b0;
		wait_for(2, 1'b1, 1200);
		check(32'(ro.join_kind), 32'(J_REJOIN));
		for (int i = 0; i < 2; i++) begin
			wait_for(2, 1'b1, 2000);
			check(32'(ro.join_kind), 32'(J_REJOIN));
		end
		wait_for(2, 1'b1, 2000);
		check(32'(ro.join_kind), 32'(J_ASSOC));
		@(posedge pclk);
		mode <= 2'h0;
		join_good <= 1'b1;
	endtask

	task automatic t_ext();
		int k;
		apb(1'b1, SN_OFS, 32'h2);
		apb(1'b1, CTRL_OFS, 32'h0010_040c);
		wait_for(1, 1'b1, 600);
		wait_for(0, 1'b0, 40);
		wait_for(1, 1'b1, 600);
		check(32'(n >= 63 * TC && n <= 65 * TC), 32'h1);
		check(32'(awake_indicator), 32'h1);
		apb(1'b1, SN_OFS, 32'h3);
		apb(1'b1, CTRL_OFS, 32'h0010_000c);
		wait_for(1, 1'b1, 600);
		k = 0;
		for (int i = 0; i < 3; i++) begin
			wait_for(1, 1'b1, 600);
			k += int'(awake_indicator === 1'b1);
		end
		check(32'(k), 32'h1);
	endtask

	task automatic t_pb();
		apb(1'b1, SN_OFS, 32'h1);
		apb(1'b1, CTRL_OFS, 32'h0010_001c);
		wait_for(0, 1'b0, 40);
		@(posedge pclk);
		pushbutton_input <= 1'b0;
		wait_for(0, 1'b1, 40);
		check(32'(n < 40), 32'h1);
		wait_for(0, 1'b0, 25000);
		check(32'(n >= 2998 * TC && n <= 3002 * TC), 32'h1);
	endtask

	// ----------------------------------------------------------------
	// Run
	// ----------------------------------------------------------------
	initial begin
		fails = 0;
		checked = 0;
		presetn = 1'b0;
		apb_req = '0;
		sleep_request_pin = 1'b1;
		pushbutton_input = 1'b1;
		ev = 3'h0;
		mode = 2'h0;
		join_good = 1'b1;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_join();
		t_regs();
		t_short();
		t_pin();
		t_hold();
		t_lost();
		t_ext();
		t_pb();
		give_verdict();
	end

	// Guards against a hang; the whole sequence needs well under this span.
	initial begin
		#240_000;
		fails++;
		give_verdict();
	end
endmodule

`default_nettype wire
